/* shared/rrx_pkg.sv */
// Package holding opcode fields, widths and reset values for the return/rotate decoder
package rrx_pkg;
  localparam int         INSTR_W        = 14;
  localparam int         DATA_W         = 8;
  localparam int         PC_W           = 13;
  localparam int         FADDR_W        = 7;
  // Literal-return: 11 01xx kkkk kkkk
  localparam logic [3:0] LITRET_MATCH   = 4'hd;
  localparam int         LITRET_LSB     = 10;
  // Plain return: 00 0000 0000 1000
  localparam logic [13:0] RETURN_CODE   = 14'h0008;
  // Rotate right through carry: 00 1100 dfff ffff
  localparam logic [5:0] ROTR_MATCH     = 6'h0c;
  localparam int         ROTR_LSB       = 8;
  localparam int         DEST_BIT       = 7;
  localparam logic [7:0] DATA_RST       = 8'h00;
  localparam logic [12:0] PC_RST        = 13'h0000;
  localparam logic [6:0] FADDR_RST      = 7'h00;
  // States of the two-cycle return sequence
  typedef enum logic [0:0] {
    RRX_EXEC  = 1'b0,
    RRX_FLUSH = 1'b1
  } rrx_state_type;
endpackage

/* logic/rrx_rotr.sv */
// Rotate-right-through-carry datapath slice
`timescale 1ns/1ns
module rrx_rotr
  import rrx_pkg::*;
(
  input  wire logic [DATA_W-1:0] operand,
  input  wire logic              carry_in,
  output logic      [DATA_W-1:0] result,
  output logic                   carry_out
);
  // Old carry enters the top, bit zero leaves into carry
  always_comb begin
    result    = {carry_in, operand[DATA_W-1:1]};
    carry_out = operand[0];
  end
endmodule

/* logic/rrx_exec.sv */
// Decode and execute for literal return, plain return and rotate right through carry
`timescale 1ns/1ns
module rrx_exec
  import rrx_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               arst_n,
  input  wire logic               instr_valid,
  input  wire logic [INSTR_W-1:0] instr_word,
  input  wire logic [PC_W-1:0]    stack_top_entry,
  input  wire logic [DATA_W-1:0]  file_rdata,
  input  wire logic               carry_flag,
  output logic      [FADDR_W-1:0] file_addr,
  output logic                    busy,
  output logic                    flush,
  output logic                    pc_load,
  output logic      [PC_W-1:0]    pc_value,
  output logic                    stack_pop,
  output logic                    w_we,
  output logic      [DATA_W-1:0]  w_wdata,
  output logic                    file_we,
  output logic      [DATA_W-1:0]  file_wdata,
  output logic                    carry_we,
  output logic                    carry_wdata
);

  // ****************************************************************
  // Timing seen by the core
  // ****************************************************************
  // A word is taken on an edge where instr_valid is high outside a flush.
  // Every strobe is registered on that edge and stands one cycle.
  // Data outputs and pc_value hold until the next write of their kind.
  // After either return the word on the bus is the stale prefetch; it is
  // dropped while busy and flush are high, so the core needs no stall.
  // file_rdata must show the register named by instr_word[6:0] in the
  // decode cycle; a core with a registered file needs its own wait stage.
  // The rotate reads carry_flag in the decode cycle; a carry write still
  // pending from the previous word must already be visible there.
  // Unknown opcodes give no strobe, so the block can share the bus with
  // the rest of the decoder without a select of its own.
  // Reset drops every strobe at once; a return cut by reset is lost and
  // the core must restart its fetch from its own reset vector.

  // ****************************************************************
  // Decode
  // ****************************************************************
  // Decode strobes and operand fields
  logic              take_ok;
  logic              litret_hit;
  logic              return_hit;
  logic              rotr_hit;
  logic              literal_return_op;
  logic              plain_return_op;
  logic              rotate_right_carry_op;
  logic              rotr_to_file;
  logic [DATA_W-1:0] literal_byte;
  logic [DATA_W-1:0] rot_result;
  logic              rot_carry;
  rrx_state_type     state_r;
  rrx_state_type     state_nxt;

  // A word is only taken outside the flush cycle;
  // the flush cycle carries the prefetch that a return has made stale
  assign take_ok = instr_valid && (state_r == RRX_EXEC);

  // Opcode field matches, independent of the take gate
  always_comb begin
    litret_hit = (instr_word[INSTR_W-1:LITRET_LSB] == LITRET_MATCH);
    return_hit = (instr_word == RETURN_CODE);
    rotr_hit   = (instr_word[INSTR_W-1:ROTR_LSB] == ROTR_MATCH);
  end

  // Qualified decodes; the three codes never overlap, so no priority is implied
  always_comb begin
    literal_return_op     = take_ok && litret_hit;
    plain_return_op       = take_ok && return_hit;
    rotate_right_carry_op = take_ok && rotr_hit;
  end

  // Operand fields of the decoded word
  always_comb begin
    literal_byte = instr_word[DATA_W-1:0];
    rotr_to_file = instr_word[DEST_BIT];
  end

  // Rotate slice works on the file value the core presents this cycle;
  // there is no read wait, so file_rdata must be combinational in the core
  rrx_rotr rrx_rotr_i (
    .operand   (file_rdata),
    .carry_in  (carry_flag),
    .result    (rot_result),
    .carry_out (rot_carry)
  );

  // ****************************************************************
  // Control sequence: program counter, stack and flush
  // ****************************************************************
  logic [FADDR_W-1:0] file_addr_nxt;
  logic               busy_nxt;
  logic               flush_nxt;
  logic               pc_load_nxt;
  logic [PC_W-1:0]    pc_value_nxt;
  logic               stack_pop_nxt;

  // Both returns take two cycles: the decode cycle and one flush cycle;
  // pc_value holds between loads so the core may sample it late
  always_comb begin
    state_nxt     = RRX_EXEC;
    file_addr_nxt = instr_word[FADDR_W-1:0];
    busy_nxt      = 1'b0;
    flush_nxt     = 1'b0;
    pc_load_nxt   = 1'b0;
    pc_value_nxt  = pc_value;
    stack_pop_nxt = 1'b0;
    unique case (state_r)
      RRX_EXEC: begin
        // Either return: load the stack top into the counter and pop it
        if (literal_return_op || plain_return_op) begin
          pc_load_nxt   = 1'b1;
          pc_value_nxt  = stack_top_entry;
          stack_pop_nxt = 1'b1;
          busy_nxt      = 1'b1;
          flush_nxt     = 1'b1;
          state_nxt     = RRX_FLUSH;
        end
      end
      RRX_FLUSH: begin
        // Second cycle only discards the prefetched word
        state_nxt     = RRX_EXEC;
        file_addr_nxt = file_addr;
      end
    endcase
  end

  // Control registers; reset leaves the sequencer ready for a word
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r   <= RRX_EXEC;
      file_addr <= FADDR_RST;
      busy      <= 1'b0;
      flush     <= 1'b0;
      pc_load   <= 1'b0;
      pc_value  <= PC_RST;
      stack_pop <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      file_addr <= file_addr_nxt;
      busy      <= busy_nxt;
      flush     <= flush_nxt;
      pc_load   <= pc_load_nxt;
      pc_value  <= pc_value_nxt;
      stack_pop <= stack_pop_nxt;
    end
  end

  // ****************************************************************
  // Data writes: accumulator, file register and carry
  // ****************************************************************
  logic              w_we_nxt;
  logic [DATA_W-1:0] w_wdata_nxt;
  logic              file_we_nxt;
  logic [DATA_W-1:0] file_wdata_nxt;
  logic              carry_we_nxt;
  logic              carry_wdata_nxt;

  // Only carry is ever written as a flag; other status bits are never touched.
  // Data values hold between writes, so a strobe may be sampled with its data.
  always_comb begin
    w_we_nxt        = 1'b0;
    w_wdata_nxt     = w_wdata;
    file_we_nxt     = 1'b0;
    file_wdata_nxt  = file_wdata;
    carry_we_nxt    = 1'b0;
    carry_wdata_nxt = carry_wdata;
    // Literal return and rotate never share one word
    if (literal_return_op) begin
      w_we_nxt    = 1'b1;
      w_wdata_nxt = literal_byte;
    end else if (rotate_right_carry_op) begin
      carry_we_nxt    = 1'b1;
      carry_wdata_nxt = rot_carry;
      if (rotr_to_file) begin
        file_we_nxt    = 1'b1;
        file_wdata_nxt = rot_result;
      end else begin
        w_we_nxt    = 1'b1;
        w_wdata_nxt = rot_result;
      end
    end
  end

  // Data registers; every write leaves the block as a registered pulse
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      w_we        <= 1'b0;
      w_wdata     <= DATA_RST;
      file_we     <= 1'b0;
      file_wdata  <= DATA_RST;
      carry_we    <= 1'b0;
      carry_wdata <= 1'b0;
    end else begin
      w_we        <= w_we_nxt;
      w_wdata     <= w_wdata_nxt;
      file_we     <= file_we_nxt;
      file_wdata  <= file_wdata_nxt;
      carry_we    <= carry_we_nxt;
      carry_wdata <= carry_wdata_nxt;
    end
  end

endmodule

/* dv/rrx_exec_assertions.sv */
// Checker for the return and rotate decoder ports
`timescale 1ns/1ns
module rrx_exec_assertions
  import rrx_pkg::*;
(
  input wire logic               clk,
  input wire logic               arst_n,
  input wire logic               instr_valid,
  input wire logic [INSTR_W-1:0] instr_word,
  input wire logic [PC_W-1:0]    stack_top_entry,
  input wire logic [DATA_W-1:0]  file_rdata,
  input wire logic               carry_flag,
  input wire logic [FADDR_W-1:0] file_addr,
  input wire logic               busy,
  input wire logic               flush,
  input wire logic               pc_load,
  input wire logic [PC_W-1:0]    pc_value,
  input wire logic               stack_pop,
  input wire logic               w_we,
  input wire logic [DATA_W-1:0]  w_wdata,
  input wire logic               file_we,
  input wire logic [DATA_W-1:0]  file_wdata,
  input wire logic               carry_we,
  input wire logic               carry_wdata
);
  // Decode mirrors; the flush cycle swallows its input
  wire logic       dec  = instr_valid && !busy;
  wire logic       lit  = dec && instr_word[13:10] == LITRET_MATCH;
  wire logic       ret  = dec && instr_word == RETURN_CODE;
  wire logic       rot  = dec && instr_word[13:8] == ROTR_MATCH;
  wire logic [7:0] rres = {carry_flag, file_rdata[7:1]};
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Steps of a return: pop and flush together in the first cycle, then quiet
  sequence ret_take;
    lit || ret;
  endsequence
  sequence pop_step;
    pc_load && stack_pop && pc_value == $past(stack_top_entry);
  endsequence
  sequence flush_step;
    busy && flush;
  endsequence
  sequence quiet_step;
    !busy && !flush && !pc_load && !stack_pop && !w_we;
  endsequence
  AST_LIT_W: assert property (
    lit |=> w_we && w_wdata == $past(instr_word[7:0]) && !carry_we && !file_we)
    else $error("literal return did not load W");
  AST_POP: assert property (
    ret_take |=> pop_step)
    else $error("return did not pop the stack top");
  AST_TWO_CYC: assert property (
    ret_take |=> flush_step ##1 quiet_step)
    else $error("return flush cycle wrong");
  AST_ROT_C: assert property (
    rot |=> carry_we && carry_wdata == $past(file_rdata[0]))
    else $error("rotate carry wrong");
  AST_ROT_W: assert property (
    rot && !instr_word[DEST_BIT] |=> w_we && !file_we && w_wdata == $past(rres))
    else $error("rotate to W wrong");
  AST_ROT_F: assert property (
    rot && instr_word[DEST_BIT] |=> file_we && !w_we && file_wdata == $past(rres))
    else $error("rotate to file wrong");
  AST_RET: assert property (
    ret |=> !w_we && !carry_we && !file_we)
    else $error("plain return wrote data");
  AST_IDLE: assert property (
    !instr_valid |=> !w_we && !file_we && !pc_load && !carry_we)
    else $error("strobe without instruction");
endmodule
bind rrx_exec rrx_exec_assertions rrx_exec_assertions_i (
  .clk             (clk),
  .arst_n          (arst_n),
  .instr_valid     (instr_valid),
  .instr_word      (instr_word),
  .stack_top_entry (stack_top_entry),
  .file_rdata      (file_rdata),
  .carry_flag      (carry_flag),
  .file_addr       (file_addr),
  .busy            (busy),
  .flush           (flush),
  .pc_load         (pc_load),
  .pc_value        (pc_value),
  .stack_pop       (stack_pop),
  .w_we            (w_we),
  .w_wdata         (w_wdata),
  .file_we         (file_we),
  .file_wdata      (file_wdata),
  .carry_we        (carry_we),
  .carry_wdata     (carry_wdata)
);

/* dv/test_rrx_exec.sv */
// Self-checking bench for the return and rotate decoder
`timescale 1ns/1ns
module test_rrx_exec;
  import rrx_pkg::*;
  logic        clk, arst_n, instr_valid, carry_flag, busy, flush, pc_load, stack_pop;
  logic        w_we, file_we, carry_we, carry_wdata;
  logic [13:0] instr_word;
  logic [12:0] stack_top_entry, pc_value;
  logic [7:0]  file_rdata, w_wdata, file_wdata;
  logic [6:0]  file_addr;
  logic [31:0] k;
  logic [6:0]  strb;
  logic        vld = 1'b1;
  logic [13:0] corner [6] = '{14'h34ab, 14'h0c90, 14'h0c10, 14'h0008, 14'h37ff, 14'h3400};
  int          err_total, checked, i, seed = 4406;
  rrx_exec rrx_exec_i (.clk(clk), .arst_n(arst_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .stack_top_entry(stack_top_entry), .file_rdata(file_rdata),
    .carry_flag(carry_flag), .file_addr(file_addr), .busy(busy), .flush(flush),
    .pc_load(pc_load), .pc_value(pc_value), .stack_pop(stack_pop), .w_we(w_we),
    .w_wdata(w_wdata), .file_we(file_we), .file_wdata(file_wdata), .carry_we(carry_we),
    .carry_wdata(carry_wdata));
  // Strobes gathered in the order used by strobes()
  assign strb = {w_we, file_we, carry_we, pc_load, stack_pop, busy, flush};
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Strobes {w, file, carry, pc, pop, busy, flush} expected per word
  function automatic logic [6:0] strobes(logic [13:0] w);
    if (w[13:10] == LITRET_MATCH) return 7'h4f;
    if (w == RETURN_CODE) return 7'h0f;
    if (w[13:8] == ROTR_MATCH) return w[DEST_BIT] ? 7'h30 : 7'h50;
    return 7'h00;
  endfunction
  // Drive one word, check one cycle later, then, after a return, the swallowed flush cycle
  task automatic step(logic [13:0] w);
    logic [6:0] s;
    logic [7:0] d;
    s = vld ? strobes(w) : 7'h00;
    d = (s == 7'h4f) ? w[7:0] : {carry_flag, file_rdata[7:1]};
    instr_valid = vld;
    instr_word = w;
    @(negedge clk);
    chk("strobes", s, strb);
    if (s[6]) chk("w_wdata", d, w_wdata);
    if (s[5]) chk("file_wdata", {w[6:0], d}, {file_addr, file_wdata});
    if (s[4]) chk("carry_wdata", file_rdata[0], carry_wdata);
    if (s[3]) chk("pc_value", stack_top_entry, pc_value);
    if (s[1]) begin
      instr_word = {LITRET_MATCH, 10'h155};
      @(negedge clk);
      chk("flush_ignore", 7'h00, strb);
    end
  endtask
  // ****************************************
  // Clock, watchdog and main sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #20000 err_total++;
    end_of_test();
  end
  initial begin
    {arst_n, instr_valid, carry_flag, instr_word} = '0;
    {stack_top_entry, file_rdata} = {13'h1abc, 8'he6};
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    // Hand-picked corners, back to back, literal bounds 00 and ff
    foreach (corner[j])
      step(corner[j]);
    $display("corner cases done");
    // Mid-run reset lands in the flush cycle of a literal return
    instr_word = 14'h34ab;
    instr_valid = 1'b1;
    @(negedge clk);
    chk("pre_reset", 7'h4f, strb);
    arst_n = 1'b0;
    instr_valid = 1'b0;
    #1;
    chk("reset_strobes", 7'h00, strb);
    chk("reset_pc", PC_RST, pc_value);
    chk("reset_w", DATA_RST, w_wdata);
    @(negedge clk);
    arst_n = 1'b1;
    $display("reset test done");
    for (i = 0; i < 300; i++) begin
      k = $random(seed);
      {stack_top_entry, carry_flag, file_rdata} = {k[28:16], k[8], k[7:0]};
      k = $random(seed);
      // One word in four arrives without instr_valid
      vld = k[19] | k[18];
      case (k[17:16])
        2'h0: step({LITRET_MATCH, k[9:0]});
        2'h1: step(RETURN_CODE);
        2'h2: step({ROTR_MATCH, k[7:0]});
        default: step(k[13:0]);
      endcase
    end
    $display("random sequence done");
    end_of_test();
  end
endmodule
